// >>> src/spcr_cfg.svh
// offsets, field positions, reset values and sizes of the serial port register block
`ifndef SPCR_CFG_SVH
`define SPCR_CFG_SVH

`define SPCR_ADDR_W 12
`define SPCR_OFS_CONF 12'h000
`define SPCR_OFS_CTRL 12'h004
`define SPCR_OFS_STAT 12'h008
`define SPCR_OFS_MASK 12'h00c
`define SPCR_OFS_RXDAT 12'h014
`define SPCR_OFS_TXDAT 12'h01c
`define SPCR_OFS_BAUD 12'h020

`define SPCR_CONF_EN 0
`define SPCR_CONF_RSVD 1
`define SPCR_CONF_LEN_LO 2
`define SPCR_CONF_LEN_HI 3
`define SPCR_CONF_PAR_LO 4
`define SPCR_CONF_PAR_HI 5
`define SPCR_CONF_STOP 6
`define SPCR_CTRL_ADET 0

`define SPCR_FLAG_W 5
`define SPCR_FLAG_TRANSMIT_READY_FLAG 0
`define SPCR_FLAG_RXRDY 1
`define SPCR_FLAG_PERR 2
`define SPCR_FLAG_FERR 3
`define SPCR_FLAG_OVR 4
`define SPCR_STAT_TXIDLE 5

`define SPCR_LEN_7 2'h0
`define SPCR_LEN_8 2'h1
`define SPCR_LEN_9 2'h2
`define SPCR_LAST_7 4'h6
`define SPCR_LAST_8 4'h7
`define SPCR_LAST_9 4'h8

`define SPCR_RST_CONF 1'b0
`define SPCR_RST_BAUD 16'h0000
`define SPCR_DATA_W 9
`define SPCR_BAUD_W 16

`endif

// >>> src/spcr_pkg.sv
// state types of the serial port transmitter and receiver
package spcr_pkg;
    typedef enum logic [4:0] {
        TX_IDLE = 5'b00001,
        TX_START = 5'b00010,
        TX_DATA = 5'b00100,
        TX_PAR = 5'b01000,
        TX_STOP = 5'b10000
    } spcr_tx_state_t;

    typedef enum logic [4:0] {
        RX_IDLE = 5'b00001,
        RX_START = 5'b00010,
        RX_DATA = 5'b00100,
        RX_PAR = 5'b01000,
        RX_STOP = 5'b10000
    } spcr_rx_state_t;
endpackage : spcr_pkg

// >>> src/spcr_sync.sv
// three-stage synchroniser for the receive pin, output follows when stages two and three agree
module spcr_sync (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic async_in,
    output logic level_out
);
    logic s1;
    logic s2;
    logic s3;

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            s1 <= 1'b1;
            s2 <= 1'b1;
            s3 <= 1'b1;
        end else begin
            s1 <= async_in;
            s2 <= s1;
            s3 <= s2;
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            level_out <= 1'b1;
        end else if (s2 == s3) begin
            level_out <= s3;
        end
    end
endmodule : spcr_sync

// >>> src/spcr_flags.sv
// sticky event flags, set has priority over a write-one clear
module spcr_flags #(
    parameter int W = 5
) (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic [W-1:0] set_in,
    input wire logic [W-1:0] clr_in,
    output logic [W-1:0] flags_out
);
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            flags_out <= '0;
        end else begin
            flags_out <= (flags_out & ~clr_in) | set_in;
        end
    end
endmodule : spcr_flags

// >>> src/spcr_top.sv
// serial port with configuration register, apb slave, transmitter, receiver and interrupt
`include "spcr_cfg.svh"
// What this block does
// - while disabled, only the configuration register accepts writes
// - configuration bit 0 is the enable, reset zero, one makes port run
// - while disabled, state machines and counters are held in reset
// - while disabled, interrupt and dma requests are all suppressed
// - settings and control bits survive a disable and re-enable
// - after re-enable the idle transmitter raises ready interrupt or dma request
// - configuration bit 1 is reserved, written as zero, reads back zero here
// - length field bits 3:2 reset 00; 0 seven bits, 1 eight bits
// - length code 2 gives nine bits, ninth bit marks an address
// - parity field bits 5:4 reset 00; 0 none, 1 reserved
// - parity code 2 even, code 3 odd, on send and receive
// - bit 6 picks one or two transmit stop bits; receiver checks one
module spcr_top (
    input wire logic SYS_CLK_IN,
    input wire logic RST_N_IN,
    input wire logic PSEL_IN,
    input wire logic PENABLE_IN,
    input wire logic PWRITE_IN,
    input wire logic [`SPCR_ADDR_W-1:0] PADDR_IN,
    input wire logic [31:0] PWDATA_IN,
    output logic [31:0] PRDATA_OUT,
    output logic PREADY_OUT,
    output logic PSLVERR_OUT,
    input wire logic RXD_IN,
    output logic TXD_OUT,
    output logic IRQ_OUT,
    output logic DMA_TX_REQ_OUT,
    output logic DMA_RX_REQ_OUT,
    output logic PORT_ENABLE_OUT,
    output logic [1:0] CHAR_LENGTH_OUT,
    output logic [1:0] PARITY_TYPE_OUT,
    output logic STOP_BITS_OUT
);
    logic port_enable;
    logic [1:0] character_length_select;
    logic [1:0] parity_type_select;
    logic stop_bit_count;
    logic address_detect_enable;
    logic [`SPCR_FLAG_W-1:0] interrupt_enable_set;
    logic [`SPCR_BAUD_W-1:0] baud_div;
    logic [`SPCR_DATA_W-1:0] tx_hold;
    logic tx_hold_full;
    logic [`SPCR_DATA_W-1:0] rx_data;
    logic rx_full;

    logic access;
    logic wr_go;
    logic rd_go;
    logic wr_ok;
    logic mapped;
    logic [31:0] next_rdata;
    logic [`SPCR_FLAG_W-1:0] flag_set;
    logic [`SPCR_FLAG_W-1:0] flag_clr;
    logic [`SPCR_FLAG_W-1:0] flags;
    logic [3:0] last_bit;
    logic par_on;
    logic par_odd;
    logic [`SPCR_DATA_W-1:0] len_mask;
    logic tx_take;
    logic rx_line;

    spcr_pkg::spcr_tx_state_t tx_state;
    logic [`SPCR_DATA_W-1:0] tx_shift;
    logic [3:0] tx_bit;
    logic tx_parity;
    logic tx_stop_left;
    logic [`SPCR_BAUD_W-1:0] tx_cnt;

    spcr_pkg::spcr_rx_state_t rx_state;
    logic [`SPCR_DATA_W-1:0] rx_shift;
    logic [3:0] rx_bit;
    logic rx_perr;
    logic [`SPCR_BAUD_W-1:0] rx_cnt;
    logic rx_done;
    logic rx_perr_evt;
    logic rx_ferr_evt;
    logic rx_ovr_evt;

    // apb: one wait state, the answer comes in the second access cycle
    assign access = PSEL_IN & PENABLE_IN & ~PREADY_OUT;
    assign wr_go = PSEL_IN & PENABLE_IN & PREADY_OUT & PWRITE_IN;
    assign rd_go = PSEL_IN & PENABLE_IN & PREADY_OUT & ~PWRITE_IN;
    // other registers are frozen until the port is enabled
    assign wr_ok = wr_go & mapped & ((PADDR_IN == `SPCR_OFS_CONF) | port_enable);

    always_comb begin
        mapped = 1'b1;
        next_rdata = 32'h0000_0000;
        case (PADDR_IN)
            `SPCR_OFS_CONF: begin
                next_rdata[`SPCR_CONF_EN] = port_enable;
                next_rdata[`SPCR_CONF_LEN_HI:`SPCR_CONF_LEN_LO] = character_length_select;
                next_rdata[`SPCR_CONF_PAR_HI:`SPCR_CONF_PAR_LO] = parity_type_select;
                next_rdata[`SPCR_CONF_STOP] = stop_bit_count;
                next_rdata[`SPCR_CONF_RSVD] = 1'b0;
            end
            `SPCR_OFS_CTRL: next_rdata[`SPCR_CTRL_ADET] = address_detect_enable;
            `SPCR_OFS_STAT: begin
                next_rdata[`SPCR_FLAG_W-1:0] = flags;
                next_rdata[`SPCR_STAT_TXIDLE] = (tx_state == spcr_pkg::TX_IDLE) & ~tx_hold_full;
            end
            `SPCR_OFS_MASK: next_rdata[`SPCR_FLAG_W-1:0] = interrupt_enable_set;
            `SPCR_OFS_RXDAT: next_rdata[`SPCR_DATA_W-1:0] = rx_data;
            `SPCR_OFS_TXDAT: next_rdata[`SPCR_DATA_W-1:0] = tx_hold;
            `SPCR_OFS_BAUD: next_rdata[`SPCR_BAUD_W-1:0] = baud_div;
            default: mapped = 1'b0;
        endcase
    end

    always_ff @(posedge SYS_CLK_IN) begin
        if (!RST_N_IN) begin
            PREADY_OUT <= 1'b0;
            PRDATA_OUT <= 32'h0000_0000;
            PSLVERR_OUT <= 1'b0;
        end else begin
            PREADY_OUT <= access;
            PSLVERR_OUT <= access & ~mapped;
            if (access) begin
                PRDATA_OUT <= PWRITE_IN ? 32'h0000_0000 : next_rdata;
            end
        end
    end

    // configuration fields keep their value across a disable; only a write changes them
    always_ff @(posedge SYS_CLK_IN) begin
        if (!RST_N_IN) begin
            port_enable <= `SPCR_RST_CONF;
            character_length_select <= `SPCR_LEN_7;
            parity_type_select <= 2'h0;
            stop_bit_count <= 1'b0;
        end else if (wr_ok && PADDR_IN == `SPCR_OFS_CONF) begin
            port_enable <= PWDATA_IN[`SPCR_CONF_EN];
            character_length_select <= PWDATA_IN[`SPCR_CONF_LEN_HI:`SPCR_CONF_LEN_LO];
            parity_type_select <= PWDATA_IN[`SPCR_CONF_PAR_HI:`SPCR_CONF_PAR_LO];
            stop_bit_count <= PWDATA_IN[`SPCR_CONF_STOP];
        end
    end

    always_ff @(posedge SYS_CLK_IN) begin
        if (!RST_N_IN) begin
            address_detect_enable <= 1'b0;
            interrupt_enable_set <= '0;
            baud_div <= `SPCR_RST_BAUD;
        end else if (wr_ok) begin
            if (PADDR_IN == `SPCR_OFS_CTRL) begin
                address_detect_enable <= PWDATA_IN[`SPCR_CTRL_ADET];
            end
            if (PADDR_IN == `SPCR_OFS_MASK) begin
                interrupt_enable_set <= PWDATA_IN[`SPCR_FLAG_W-1:0];
            end
            if (PADDR_IN == `SPCR_OFS_BAUD) begin
                baud_div <= PWDATA_IN[`SPCR_BAUD_W-1:0];
            end
        end
    end

    // decode of the character format; reserved codes fall back to eight bits and no parity
    always_comb begin
        case (character_length_select)
            `SPCR_LEN_7: last_bit = `SPCR_LAST_7;
            `SPCR_LEN_8: last_bit = `SPCR_LAST_8;
            `SPCR_LEN_9: last_bit = `SPCR_LAST_9;
            default: last_bit = `SPCR_LAST_8;
        endcase
    end
    assign len_mask = ~(9'h1fe << last_bit);
    assign par_on = parity_type_select[1];
    assign par_odd = parity_type_select[0];

    // the holding register belongs to the transmitter and empties when the port is off
    assign tx_take = (tx_state == spcr_pkg::TX_IDLE) & tx_hold_full;
    always_ff @(posedge SYS_CLK_IN) begin
        if (!RST_N_IN) begin
            tx_hold <= '0;
            tx_hold_full <= 1'b0;
        end else if (!port_enable) begin
            tx_hold_full <= 1'b0;
        end else if (wr_ok && PADDR_IN == `SPCR_OFS_TXDAT) begin
            tx_hold <= PWDATA_IN[`SPCR_DATA_W-1:0];
            tx_hold_full <= 1'b1;
        end else if (tx_take) begin
            tx_hold_full <= 1'b0;
        end
    end

    always_ff @(posedge SYS_CLK_IN) begin
        if (!RST_N_IN || !port_enable) begin
            tx_state <= spcr_pkg::TX_IDLE;
            tx_shift <= '0;
            tx_bit <= 4'h0;
            tx_parity <= 1'b0;
            tx_stop_left <= 1'b0;
            tx_cnt <= `SPCR_RST_BAUD;
            TXD_OUT <= 1'b1;
        end else if (tx_state == spcr_pkg::TX_IDLE) begin
            tx_cnt <= baud_div;
            if (tx_hold_full) begin
                tx_shift <= tx_hold & len_mask;
                tx_parity <= (^(tx_hold & len_mask)) ^ par_odd;
                tx_bit <= 4'h0;
                tx_state <= spcr_pkg::TX_START;
                TXD_OUT <= 1'b0;
            end
        end else if (tx_cnt != '0) begin
            tx_cnt <= tx_cnt - 16'h0001;
        end else begin
            tx_cnt <= baud_div;
            case (tx_state)
                spcr_pkg::TX_START: begin
                    tx_state <= spcr_pkg::TX_DATA;
                    TXD_OUT <= tx_shift[0];
                end
                spcr_pkg::TX_DATA: begin
                    if (tx_bit == last_bit) begin
                        if (par_on) begin
                            tx_state <= spcr_pkg::TX_PAR;
                            TXD_OUT <= tx_parity;
                        end else begin
                            tx_state <= spcr_pkg::TX_STOP;
                            TXD_OUT <= 1'b1;
                            tx_stop_left <= stop_bit_count;
                        end
                    end else begin
                        tx_bit <= tx_bit + 4'h1;
                        tx_shift <= tx_shift >> 1;
                        TXD_OUT <= tx_shift[1];
                    end
                end
                spcr_pkg::TX_PAR: begin
                    tx_state <= spcr_pkg::TX_STOP;
                    TXD_OUT <= 1'b1;
                    tx_stop_left <= stop_bit_count;
                end
                spcr_pkg::TX_STOP: begin
                    if (tx_stop_left) begin
                        tx_stop_left <= 1'b0;
                    end else begin
                        tx_state <= spcr_pkg::TX_IDLE;
                    end
                end
                default: tx_state <= spcr_pkg::TX_IDLE;
            endcase
        end
    end

    spcr_sync u_rx_sync (
        .clk_in(SYS_CLK_IN),
        .rst_n_in(RST_N_IN),
        .async_in(RXD_IN),
        .level_out(rx_line)
    );

    // half a bit after the falling edge the line is sampled once per bit time
    always_ff @(posedge SYS_CLK_IN) begin
        if (!RST_N_IN || !port_enable) begin
            rx_state <= spcr_pkg::RX_IDLE;
            rx_shift <= '0;
            rx_bit <= 4'h0;
            rx_perr <= 1'b0;
            rx_cnt <= `SPCR_RST_BAUD;
            rx_done <= 1'b0;
            rx_perr_evt <= 1'b0;
            rx_ferr_evt <= 1'b0;
        end else begin
            rx_done <= 1'b0;
            rx_perr_evt <= 1'b0;
            rx_ferr_evt <= 1'b0;
            if (rx_state == spcr_pkg::RX_IDLE) begin
                rx_cnt <= baud_div >> 1;
                if (!rx_line) begin
                    rx_state <= spcr_pkg::RX_START;
                end
            end else if (rx_cnt != '0) begin
                rx_cnt <= rx_cnt - 16'h0001;
            end else begin
                rx_cnt <= baud_div;
                case (rx_state)
                    spcr_pkg::RX_START: begin
                        rx_shift <= '0;
                        rx_bit <= 4'h0;
                        rx_perr <= 1'b0;
                        rx_state <= rx_line ? spcr_pkg::RX_IDLE : spcr_pkg::RX_DATA;
                    end
                    spcr_pkg::RX_DATA: begin
                        rx_shift[rx_bit] <= rx_line;
                        if (rx_bit == last_bit) begin
                            rx_state <= par_on ? spcr_pkg::RX_PAR : spcr_pkg::RX_STOP;
                        end else begin
                            rx_bit <= rx_bit + 4'h1;
                        end
                    end
                    spcr_pkg::RX_PAR: begin
                        rx_perr <= (^rx_shift) ^ rx_line ^ par_odd;
                        rx_state <= spcr_pkg::RX_STOP;
                    end
                    spcr_pkg::RX_STOP: begin
                        // one stop bit is enough; a second one is just idle line
                        rx_state <= spcr_pkg::RX_IDLE;
                        // with address detect on, nine-bit data without the marker is dropped
                        if (!(address_detect_enable && character_length_select == `SPCR_LEN_9
                              && !rx_shift[8])) begin
                            rx_done <= 1'b1;
                            rx_perr_evt <= rx_perr;
                            rx_ferr_evt <= ~rx_line;
                        end
                    end
                    default: rx_state <= spcr_pkg::RX_IDLE;
                endcase
            end
        end
    end

    // a new character beats a read in the same cycle so it is never lost
    always_ff @(posedge SYS_CLK_IN) begin
        if (!RST_N_IN) begin
            rx_data <= '0;
            rx_full <= 1'b0;
            rx_ovr_evt <= 1'b0;
        end else if (!port_enable) begin
            rx_full <= 1'b0;
            rx_ovr_evt <= 1'b0;
        end else begin
            rx_ovr_evt <= rx_done & rx_full & ~(rd_go && PADDR_IN == `SPCR_OFS_RXDAT);
            if (rx_done) begin
                rx_data <= rx_shift;
                rx_full <= 1'b1;
            end else if (rd_go && PADDR_IN == `SPCR_OFS_RXDAT) begin
                rx_full <= 1'b0;
            end
        end
    end

    always_comb begin
        flag_set = '0;
        flag_set[`SPCR_FLAG_TRANSMIT_READY_FLAG] = port_enable & ~tx_hold_full;
        flag_set[`SPCR_FLAG_RXRDY] = rx_done;
        flag_set[`SPCR_FLAG_PERR] = rx_perr_evt;
        flag_set[`SPCR_FLAG_FERR] = rx_ferr_evt;
        flag_set[`SPCR_FLAG_OVR] = rx_ovr_evt;
        flag_clr = '0;
        if (wr_ok && PADDR_IN == `SPCR_OFS_STAT) begin
            flag_clr = PWDATA_IN[`SPCR_FLAG_W-1:0];
        end
    end

    spcr_flags #(
        .W(`SPCR_FLAG_W)
    ) u_flags (
        .clk_in(SYS_CLK_IN),
        .rst_n_in(RST_N_IN),
        .set_in(flag_set),
        .clr_in(flag_clr),
        .flags_out(flags)
    );

    always_ff @(posedge SYS_CLK_IN) begin
        if (!RST_N_IN) begin
            IRQ_OUT <= 1'b0;
            DMA_TX_REQ_OUT <= 1'b0;
            DMA_RX_REQ_OUT <= 1'b0;
            PORT_ENABLE_OUT <= 1'b0;
            CHAR_LENGTH_OUT <= 2'h0;
            PARITY_TYPE_OUT <= 2'h0;
            STOP_BITS_OUT <= 1'b0;
        end else begin
            IRQ_OUT <= port_enable & (|(flags & interrupt_enable_set));
            DMA_TX_REQ_OUT <= port_enable & ~tx_hold_full;
            DMA_RX_REQ_OUT <= port_enable & rx_full;
            PORT_ENABLE_OUT <= port_enable;
            CHAR_LENGTH_OUT <= character_length_select;
            PARITY_TYPE_OUT <= parity_type_select;
            STOP_BITS_OUT <= stop_bit_count;
        end
    end
endmodule : spcr_top

// >>> verification/spcr_top_monitor.sv
// port-level assertions for the serial port register block
`include "spcr_cfg.svh"
module spcr_top_monitor (
    input wire logic SYS_CLK_IN,
    input wire logic RST_N_IN,
    input wire logic PSEL_IN,
    input wire logic PENABLE_IN,
    input wire logic PWRITE_IN,
    input wire logic [`SPCR_ADDR_W-1:0] PADDR_IN,
    input wire logic [31:0] PWDATA_IN,
    input wire logic [31:0] PRDATA_OUT,
    input wire logic PREADY_OUT,
    input wire logic PSLVERR_OUT,
    input wire logic TXD_OUT,
    input wire logic IRQ_OUT,
    input wire logic DMA_TX_REQ_OUT,
    input wire logic DMA_RX_REQ_OUT,
    input wire logic PORT_ENABLE_OUT,
    input wire logic [1:0] CHAR_LENGTH_OUT,
    input wire logic [1:0] PARITY_TYPE_OUT,
    input wire logic STOP_BITS_OUT
);
    timeunit 1ns;
    timeprecision 1ps;
    logic mapped;
    logic conf_wr;
    logic conf_rd;
    always_comb begin
        mapped = PADDR_IN inside {`SPCR_OFS_CONF, `SPCR_OFS_CTRL, `SPCR_OFS_STAT,
            `SPCR_OFS_MASK, `SPCR_OFS_RXDAT, `SPCR_OFS_TXDAT, `SPCR_OFS_BAUD};
    end
    assign conf_wr = PSEL_IN && PENABLE_IN && PREADY_OUT && PWRITE_IN
        && PADDR_IN == `SPCR_OFS_CONF;
    assign conf_rd = PSEL_IN && PENABLE_IN && PREADY_OUT && !PWRITE_IN
        && PADDR_IN == `SPCR_OFS_CONF;

    default clocking mon_cb @(posedge SYS_CLK_IN);
    endclocking
    default disable iff (!RST_N_IN);

    ready_wait_a: assert property (PSEL_IN && PENABLE_IN && !PREADY_OUT |=> PREADY_OUT)
        else $error("answer did not follow one access cycle");
    ready_pulse_a: assert property (PREADY_OUT |=> !PREADY_OUT)
        else $error("ready stayed high");
    slverr_map_a: assert property (PSEL_IN && PENABLE_IN && PREADY_OUT |-> PSLVERR_OUT == !mapped)
        else $error("error response does not match address map");
    enable_copy_a: assert property (conf_wr |-> ##2 PORT_ENABLE_OUT == $past(PWDATA_IN[0], 2))
        else $error("enable does not follow written bit");
    field_copy_a: assert property (conf_wr |-> ##2
        {STOP_BITS_OUT, PARITY_TYPE_OUT, CHAR_LENGTH_OUT} == $past(PWDATA_IN[6:2], 2))
        else $error("format fields do not follow written value");
    field_hold_a: assert property (!conf_wr [*2] |=>
        $stable({PORT_ENABLE_OUT, STOP_BITS_OUT, PARITY_TYPE_OUT, CHAR_LENGTH_OUT}))
        else $error("format fields changed without a write");
    quiet_off_a: assert property (!PORT_ENABLE_OUT |->
        !IRQ_OUT && !DMA_TX_REQ_OUT && !DMA_RX_REQ_OUT)
        else $error("request raised while disabled");
    line_idle_a: assert property (!PORT_ENABLE_OUT [*3] |-> TXD_OUT)
        else $error("transmit line active while disabled");
    ready_reenable_a: assert property ($rose(PORT_ENABLE_OUT) |-> ##[0:1] DMA_TX_REQ_OUT)
        else $error("no transmit request after enabling");
    rsvd_zero_a: assert property (conf_rd |-> PRDATA_OUT[1] == 1'b0 && PRDATA_OUT[31:7] == '0)
        else $error("reserved configuration bits read nonzero");
endmodule : spcr_top_monitor

bind spcr_top spcr_top_monitor u_mon (
    .SYS_CLK_IN, .RST_N_IN, .PSEL_IN, .PENABLE_IN, .PWRITE_IN, .PADDR_IN, .PWDATA_IN,
    .PRDATA_OUT, .PREADY_OUT, .PSLVERR_OUT, .TXD_OUT, .IRQ_OUT, .DMA_TX_REQ_OUT,
    .DMA_RX_REQ_OUT, .PORT_ENABLE_OUT, .CHAR_LENGTH_OUT, .PARITY_TYPE_OUT, .STOP_BITS_OUT
);

// >>> verification/spcr_top_tb.sv
// self-checking bench for the serial port register block
`include "spcr_cfg.svh"
module spcr_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic psel = 1'b0;
    logic pen = 1'b0;
    logic pwr = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic rxd = 1'b1;
    logic [31:0] prdata;
    logic pready, pslverr, txd, irq, dma_tx, dma_rx, en_o, stop_o;
    logic [1:0] len_o, par_o;
    logic [31:0] rd;
    logic er;
    int err_count = 0;
    int samples_checked = 0;

    always #2 clk = ~clk;

    spcr_top u_dut (.SYS_CLK_IN(clk), .RST_N_IN(rst_n), .PSEL_IN(psel), .PENABLE_IN(pen),
        .PWRITE_IN(pwr), .PADDR_IN(paddr), .PWDATA_IN(pwdata), .PRDATA_OUT(prdata),
        .PREADY_OUT(pready), .PSLVERR_OUT(pslverr), .RXD_IN(rxd), .TXD_OUT(txd),
        .IRQ_OUT(irq), .DMA_TX_REQ_OUT(dma_tx), .DMA_RX_REQ_OUT(dma_rx),
        .PORT_ENABLE_OUT(en_o), .CHAR_LENGTH_OUT(len_o), .PARITY_TYPE_OUT(par_o),
        .STOP_BITS_OUT(stop_o));

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        samples_checked++;
        if (got !== exp) begin
            err_count++;
            $display("FAIL t=%0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : chk

    task automatic conclude();
        $display("checks %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : conclude

    // request held until ready is sampled high; one idle cycle between transfers
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        psel <= 1'b1;
        pwr <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        pen <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        pen <= 1'b0;
        chk(n < 16, 1, "bus answer");
    endtask : apb

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask : wr

    task automatic rdx(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(rd, exp, "read back");
    endtask : rdx

    function automatic logic [31:0] cfgv(logic en, logic [1:0] ln, logic [1:0] pr, logic st);
        return {25'h0, st, pr, ln, 1'b0, en};
    endfunction : cfgv

    task automatic s_locked();
        rdx(`SPCR_OFS_CONF, 32'h0);
        wr(`SPCR_OFS_BAUD, 32'hab);
        wr(`SPCR_OFS_MASK, 32'h1);
        rdx(`SPCR_OFS_BAUD, 32'h0);
        rdx(`SPCR_OFS_MASK, 32'h0);
        wr(`SPCR_OFS_CONF, cfgv(1'b1, 2'h1, 2'h0, 1'b0));
        wr(`SPCR_OFS_BAUD, 32'hab);
        rdx(`SPCR_OFS_BAUD, 32'hab);
        apb(1'b0, 12'h040, 32'h0);
        chk(er, 1, "unmapped error");
        chk(rd, 0, "unmapped data");
    endtask : s_locked

    task automatic s_fields();
        for (int i = 0; i < 16; i++) begin
            wr(`SPCR_OFS_CONF, cfgv(1'b1, i[1:0], i[3:2], i[0]));
            rdx(`SPCR_OFS_CONF, cfgv(1'b1, i[1:0], i[3:2], i[0]));
            chk({stop_o, par_o, len_o}, {i[0], i[3:2], i[1:0]}, "field copies");
        end
    endtask : s_fields

    task automatic s_reenable();
        wr(`SPCR_OFS_CONF, cfgv(1'b1, 2'h2, 2'h3, 1'b1));
        wr(`SPCR_OFS_MASK, 32'h1);
        repeat (3) @(negedge clk);
        chk(irq, 1, "ready interrupt");
        wr(`SPCR_OFS_CONF, cfgv(1'b0, 2'h2, 2'h3, 1'b1));
        repeat (3) @(negedge clk);
        chk({irq, dma_tx, dma_rx}, 3'b000, "quiet while off");
        chk({en_o, stop_o, par_o, len_o}, 6'b011110, "kept fields");
        rdx(`SPCR_OFS_MASK, 32'h1);
        rdx(`SPCR_OFS_BAUD, 32'hab);
        wr(`SPCR_OFS_CONF, cfgv(1'b1, 2'h2, 2'h3, 1'b1));
        repeat (2) @(posedge clk);
        @(negedge clk);
        chk({irq, dma_tx}, 2'b11, "ready after enable");
        wr(`SPCR_OFS_MASK, 32'h0);
        repeat (3) @(negedge clk);
        chk(irq, 0, "masked interrupt");
    endtask : s_reenable

    // two characters back to back, so a missing second stop bit shifts the next start
    task automatic tx_pair(input logic [1:0] ln, input logic [1:0] pr, input logic st,
                           input logic [8:0] d);
        logic q[$];
        logic [8:0] c;
        int nb;
        int n;
        nb = (ln == 2'h0) ? 7 : ((ln == 2'h2) ? 9 : 8);
        for (int j = 0; j < 2; j++) begin
            c = j ? ~d : d;
            q.push_back(1'b0);
            for (int k = 0; k < nb; k++) begin
                q.push_back(c[k]);
            end
            if (pr[1]) begin
                q.push_back(pr[0] ^ (^(c & ((9'h1 << nb) - 9'h1))));
            end
            q.push_back(1'b1);
            if (st) begin
                q.push_back(1'b1);
            end
        end
        q.push_back(1'b1);
        q.push_back(1'b1);
        wr(`SPCR_OFS_CONF, 32'h0);
        wr(`SPCR_OFS_CONF, cfgv(1'b1, ln, pr, st));
        wr(`SPCR_OFS_BAUD, 32'h3);
        wr(`SPCR_OFS_TXDAT, {23'h0, d});
        fork
            wr(`SPCR_OFS_TXDAT, {23'h0, ~d});
            begin
                n = 0;
                while (txd !== 1'b0 && n < 64) begin
                    @(negedge clk);
                    n++;
                end
                foreach (q[k]) begin
                    repeat (k == 0 ? 2 : 4) @(negedge clk);
                    chk(txd, q[k], "tx line");
                end
            end
        join
    endtask : tx_pair

    task automatic s_abort();
        int n;
        wr(`SPCR_OFS_TXDAT, 32'h0);
        repeat (8) @(posedge clk);
        for (int p = 0; p < 2; p++) begin
            wr(`SPCR_OFS_CONF, cfgv(p[0], 2'h1, 2'h0, 1'b0));
            repeat (3) @(negedge clk);
            n = 0;
            repeat (40) begin
                @(negedge clk);
                n += (txd !== 1'b1);
            end
            chk(n, 0, "line idle after abort");
        end
        chk(dma_tx, 1, "ready after abort");
    endtask : s_abort

    // one eight-bit frame with even parity into the receiver; bad flips the parity bit
    task automatic s_rx(input logic [7:0] d, input logic bad);
        logic [10:0] f;
        f = {1'b1, bad ^ (^d), d, 1'b0};
        for (int k = 0; k < 11; k++) begin
            rxd <= f[k];
            repeat (4) @(posedge clk);
        end
        repeat (8) @(posedge clk);
        chk(dma_rx, 1, "receive request");
        rdx(`SPCR_OFS_STAT, {26'h0, 3'h4, bad, 2'h3});
        rdx(`SPCR_OFS_RXDAT, {24'h0, d});
    endtask : s_rx

    initial begin
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        s_locked();
        s_fields();
        s_reenable();
        tx_pair(2'h2, 2'h2, 1'b1, 9'h1a5);
        tx_pair(2'h0, 2'h3, 1'b0, 9'h05a);
        tx_pair(2'h3, 2'h1, 1'b0, 9'h0c3);
        s_abort();
        wr(`SPCR_OFS_CONF, 32'h0);
        wr(`SPCR_OFS_CONF, cfgv(1'b1, 2'h1, 2'h2, 1'b1));
        s_rx(8'h96, 1'b0);
        s_rx(8'h3c, 1'b1);
        conclude();
    end

    // whole run needs well under two thousand cycles
    initial begin
        repeat (8000) @(posedge clk);
        err_count++;
        conclude();
    end
endmodule : spcr_top_tb
